// ---- logic/word_shift_rotate_unit.v ----
// Purpose: Zero-swap word shifter and 16-bit shift and rotate datapath
// Assumes: APB slave, one wait state, word store held in flip-flops
// Notes: An operation runs at the edge that completes its command write
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "word_shift_rotate_unit_regs.vh"

module word_shift_rotate_unit #(
	parameter DEPTH = 16,
	parameter AW = 4,
	parameter AREA_WORDS = 8
) (
	// Clock and reset
	input wire clk_i,
	input wire rst_n_i,
	// APB slave
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [11:0] paddr_i,
	input wire [31:0] pwdata_i,
	output wire pready_o,
	output wire [31:0] prdata_o,
	output wire pslverr_o,
	// Interrupt
	output wire irq_o
);

////////////////////////////////////////////////////////////////////////////
// Decode helpers

function mem_hit;
	input [11:0] a;
	begin
		mem_hit = (a >= `MEM_BASE) && (a < `MEM_BASE + 4 * DEPTH) &&
			(a[1:0] == 2'b00);
	end
endfunction

function [AW:0] resolve;
	input [15:0] v;
	input ind;
	reg bad;
	reg [15:0] val;
	begin
		bad = 1'b0;
		val = v;
		if (ind) begin
			bad = (v[15:12] > 4'h9) | (v[11:8] > 4'h9) |
				(v[7:4] > 4'h9) | (v[3:0] > 4'h9);
			val = v[15:12] * 16'd1000 + v[11:8] * 16'd100 +
				v[7:4] * 16'd10 + {12'h000, v[3:0]};
		end
		if (val >= DEPTH) begin
			bad = 1'b1;
		end
		resolve = {bad, val[AW-1:0]};
	end
endfunction

////////////////////////////////////////////////////////////////////////////
// State

reg [15:0] mem_reg [0:DEPTH-1];
reg [15:0] ctrl_reg;
reg [15:0] lower_reg;
reg [15:0] upper_reg;
reg [15:0] opnd_reg;
reg carry_reg;
reg zero_reg;
reg fault_reg;
reg [1:0] irq_stat_reg;
reg [1:0] irq_en_reg;
reg ready_reg;
reg slverr_reg;
reg [31:0] prdata_reg;

////////////////////////////////////////////////////////////////////////////
// APB access

wire access = psel_i & penable_i;
wire wr_en = access & pwrite_i & ready_reg;
wire cmd_wr = wr_en && (paddr_i == `CMD_OFS);
wire [2:0] op = pwdata_i[`CMD_OP_MSB:0];
wire cond_on = pwdata_i[`CMD_COND_BIT];
wire ind = pwdata_i[`CMD_IND_BIT];
wire exec = cmd_wr & cond_on;
wire [AW-1:0] mem_idx = paddr_i[AW+1:2];

assign pready_o = ready_reg;
assign prdata_o = prdata_reg;
assign pslverr_o = slverr_reg;

reg [31:0] rd_mux;
reg rd_bad;
always @* begin
	rd_mux = 32'h0000_0000;
	rd_bad = 1'b0;
	if (paddr_i == `CMD_OFS) begin
		rd_mux = 32'h0000_0000;
	end else if (paddr_i == `CTRL_OFS) begin
		rd_mux = {16'h0000, ctrl_reg};
	end else if (paddr_i == `LOWER_OFS) begin
		rd_mux = {16'h0000, lower_reg};
	end else if (paddr_i == `UPPER_OFS) begin
		rd_mux = {16'h0000, upper_reg};
	end else if (paddr_i == `OPND_OFS) begin
		rd_mux = {16'h0000, opnd_reg};
	end else if (paddr_i == `FLAGS_OFS) begin
		rd_mux = {29'h0000_0000, fault_reg, zero_reg, carry_reg};
	end else if (paddr_i == `IRQ_STAT_OFS) begin
		rd_mux = {30'h0000_0000, irq_stat_reg};
	end else if (paddr_i == `IRQ_CLR_OFS) begin
		rd_mux = 32'h0000_0000;
	end else if (paddr_i == `IRQ_EN_OFS) begin
		rd_mux = {30'h0000_0000, irq_en_reg};
	end else if (mem_hit(paddr_i)) begin
		rd_mux = {16'h0000, mem_reg[mem_idx]};
	end else begin
		rd_bad = 1'b1;
	end
end

always @(posedge clk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		ready_reg <= 1'b0;
		slverr_reg <= 1'b0;
		prdata_reg <= 32'h0000_0000;
	end else if (access && !ready_reg) begin
		ready_reg <= 1'b1;
		slverr_reg <= rd_bad;
		prdata_reg <= pwrite_i ? 32'h0000_0000 : rd_mux;
	end else begin
		ready_reg <= 1'b0;
		slverr_reg <= 1'b0;
	end
end

////////////////////////////////////////////////////////////////////////////
// Operand resolution and range checks

wire [AW:0] lo_res = resolve(lower_reg, ind);
wire [AW:0] hi_res = resolve(upper_reg, ind);
wire [AW:0] op_res = resolve(opnd_reg, ind);
wire [AW-1:0] lo_idx = lo_res[AW-1:0];
wire [AW-1:0] hi_idx = hi_res[AW-1:0];
wire [AW-1:0] op_idx = op_res[AW-1:0];
wire range_bad = lo_res[AW] | hi_res[AW] |
	((lo_idx / AREA_WORDS) != (hi_idx / AREA_WORDS)) |
	(lo_idx > hi_idx);
wire is_word_op = (op == `OP_ASL) || (op == `OP_ASR) ||
	(op == `OP_ROL) || (op == `OP_ROR);
wire op_fault = (op == `OP_ZSWAP) ? range_bad :
	(is_word_op ? op_res[AW] : 1'b0);

// Only bits 13 to 15 of the control word are decoded
wire dir_down = ctrl_reg[`CTRL_DIR_BIT];
wire sh_en = ctrl_reg[`CTRL_EN_BIT];
wire clr_rng = ctrl_reg[`CTRL_RST_BIT];

////////////////////////////////////////////////////////////////////////////
// Zero-swap next values, from the old snapshot only

wire [15:0] swap_w [0:DEPTH-1];
genvar gi;
generate
	for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_word
		localparam [AW-1:0] IDX = gi;
		wire [15:0] cur = mem_reg[gi];
		wire [15:0] prv;
		wire [15:0] nxt;
		wire has_prv;
		wire has_nxt;
		wire in_rng = (IDX >= lo_idx) && (IDX <= hi_idx);
		if (gi == 0) begin : g_lo
			assign prv = 16'h0000;
			assign has_prv = 1'b0;
		end else begin : g_lo
			localparam [AW-1:0] PRV = gi - 1;
			assign prv = mem_reg[gi-1];
			assign has_prv = (PRV >= lo_idx);
		end
		if (gi == DEPTH - 1) begin : g_hi
			assign nxt = 16'h0000;
			assign has_nxt = 1'b0;
		end else begin : g_hi
			localparam [AW-1:0] NXT = gi + 1;
			assign nxt = mem_reg[gi+1];
			assign has_nxt = (NXT <= hi_idx);
		end
		// Feeder and receiver neighbour by direction
		wire [15:0] feed = dir_down ? nxt : prv;
		wire has_feed = dir_down ? has_nxt : has_prv;
		wire [15:0] recv = dir_down ? prv : nxt;
		wire has_recv = dir_down ? has_prv : has_nxt;
		wire take = (cur == 16'h0000) && has_feed &&
			(feed != 16'h0000);
		wire give = (cur != 16'h0000) && has_recv &&
			(recv == 16'h0000);
		assign swap_w[gi] = !in_rng ? cur :
			clr_rng ? 16'h0000 :
			!sh_en ? cur :
			take ? feed :
			give ? 16'h0000 : cur;
	end
endgenerate

////////////////////////////////////////////////////////////////////////////
// Single word shift and rotate

wire [15:0] opw = mem_reg[op_idx];
reg [15:0] sh_res;
reg sh_carry;
always @* begin
	sh_res = opw;
	sh_carry = carry_reg;
	case (op)
		`OP_ASL: begin
			sh_res = {opw[14:0], 1'b0};
			sh_carry = opw[15];
		end
		`OP_ASR: begin
			sh_res = {1'b0, opw[15:1]};
			sh_carry = opw[0];
		end
		`OP_ROL: begin
			sh_res = {opw[14:0], carry_reg};
			sh_carry = opw[15];
		end
		`OP_ROR: begin
			sh_res = {carry_reg, opw[15:1]};
			sh_carry = opw[0];
		end
		default: begin
			sh_res = opw;
			sh_carry = carry_reg;
		end
	endcase
end

////////////////////////////////////////////////////////////////////////////
// Word store

integer k;
always @(posedge clk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		for (k = 0; k < DEPTH; k = k + 1) begin
			mem_reg[k] <= `WORD_RST;
		end
	end else if (exec && !op_fault) begin
		if (op == `OP_ZSWAP) begin
			for (k = 0; k < DEPTH; k = k + 1) begin
				mem_reg[k] <= swap_w[k];
			end
		end else if (is_word_op) begin
			mem_reg[op_idx] <= sh_res;
		end
	end else if (wr_en && mem_hit(paddr_i)) begin
		mem_reg[mem_idx] <= pwdata_i[15:0];
	end
end

////////////////////////////////////////////////////////////////////////////
// Control registers and flags

always @(posedge clk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		ctrl_reg <= `CTRL_RST;
		lower_reg <= `BOUND_RST;
		upper_reg <= `BOUND_RST;
		opnd_reg <= `BOUND_RST;
		irq_en_reg <= 2'b00;
	end else if (wr_en) begin
		if (paddr_i == `CTRL_OFS) begin
			ctrl_reg <= pwdata_i[15:0];
		end else if (paddr_i == `LOWER_OFS) begin
			lower_reg <= pwdata_i[15:0];
		end else if (paddr_i == `UPPER_OFS) begin
			upper_reg <= pwdata_i[15:0];
		end else if (paddr_i == `OPND_OFS) begin
			opnd_reg <= pwdata_i[15:0];
		end else if (paddr_i == `IRQ_EN_OFS) begin
			irq_en_reg <= pwdata_i[1:0];
		end
	end
end

always @(posedge clk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		carry_reg <= 1'b0;
		zero_reg <= 1'b0;
		fault_reg <= 1'b0;
	end else if (exec) begin
		fault_reg <= op_fault;
		if (op == `OP_CSET) begin
			carry_reg <= 1'b1;
		end else if (op == `OP_CCLR) begin
			carry_reg <= 1'b0;
		end else if (is_word_op && !op_fault) begin
			carry_reg <= sh_carry;
			zero_reg <= (sh_res == 16'h0000);
		end
	end
end

////////////////////////////////////////////////////////////////////////////
// Interrupts, set wins over clear

wire [1:0] irq_set = {exec & op_fault, exec};
wire [1:0] irq_clr = (wr_en && (paddr_i == `IRQ_CLR_OFS)) ?
	pwdata_i[1:0] : 2'b00;

always @(posedge clk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		irq_stat_reg <= 2'b00;
	end else begin
		irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
	end
end

assign irq_o = |(irq_stat_reg & irq_en_reg);

endmodule

// ---- logic/word_shift_rotate_unit_regs.vh ----
// Purpose: Offsets, fields, codes and reset values of the shift unit
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: Included by the shift unit, its monitor and its bench
`ifndef WORD_SHIFT_ROTATE_UNIT_REGS_VH
`define WORD_SHIFT_ROTATE_UNIT_REGS_VH

// Register byte offsets
`define CMD_OFS 12'h000
`define CTRL_OFS 12'h004
`define LOWER_OFS 12'h008
`define UPPER_OFS 12'h00C
`define OPND_OFS 12'h010
`define FLAGS_OFS 12'h014
`define IRQ_STAT_OFS 12'h018
`define IRQ_CLR_OFS 12'h01C
`define IRQ_EN_OFS 12'h020
`define MEM_BASE 12'h040

// Command fields and operation codes
`define CMD_OP_MSB 2
`define CMD_COND_BIT 3
`define CMD_IND_BIT 4
`define OP_ZSWAP 3'h0
`define OP_ASL 3'h1
`define OP_ASR 3'h2
`define OP_ROL 3'h3
`define OP_ROR 3'h4
`define OP_CSET 3'h5
`define OP_CCLR 3'h6

// Control word bits
`define CTRL_DIR_BIT 13
`define CTRL_EN_BIT 14
`define CTRL_RST_BIT 15

// Flag and interrupt bits
`define FLG_CARRY 0
`define FLG_ZERO 1
`define FLG_FAULT 2
`define IRQ_DONE 0
`define IRQ_FAULT 1

// Reset values
`define CTRL_RST 16'h0000
`define BOUND_RST 16'h0000
`define WORD_RST 16'h0000

`endif

// ---- verif/word_shift_rotate_unit_monitor.sv ----
// Purpose: Port-level checks of the shift unit
// Assumes: APB slave with one wait state
// Notes: Attached by bind at the foot of this file
`timescale 1ns/1ps
`include "word_shift_rotate_unit_regs.vh"
module shift_unit_monitor (
	input wire clk_i,
	input wire rst_n_i,
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [11:0] paddr_i,
	input wire [31:0] pwdata_i,
	input wire pready_o,
	input wire [31:0] prdata_o,
	input wire pslverr_o,
	input wire irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	a_ready_one_wait: assert property (psel_i && penable_i &&
		!$past(penable_i) |-> !pready_o ##1 pready_o) else $error("late ready");
	a_ready_pulse: assert property (pready_o |=> !pready_o)
		else $error("ready held");
	a_ready_in_access: assert property (pready_o |-> psel_i && penable_i)
		else $error("ready outside access");
	a_err_with_ready: assert property (pslverr_o |-> pready_o)
		else $error("error without ready");
	a_cmd_reads_zero: assert property (pready_o && !pwrite_i &&
		paddr_i == `CMD_OFS |-> prdata_o == 0) else $error("command readable");
	a_flags_narrow: assert property (pready_o && !pwrite_i &&
		paddr_i == `FLAGS_OFS |-> prdata_o[31:3] == 0) else $error("flag bits");
	a_word_narrow: assert property (pready_o && !pwrite_i |->
		prdata_o[31:16] == 16'h0000) else $error("upper read bits");
	a_err_unmapped: assert property (pready_o && paddr_i == 12'h024 |->
		pslverr_o) else $error("unmapped accepted");
	a_irq_cleared: assert property (pready_o && pwrite_i &&
		paddr_i == `IRQ_CLR_OFS && pwdata_i[1:0] == 2'b11 |=> !irq_o)
		else $error("irq after clear");
endmodule
bind word_shift_rotate_unit shift_unit_monitor u_mon (.clk_i(clk_i),
	.rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
	.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
	.pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
	.irq_o(irq_o));

// ---- verif/sequencer_model.sv ----
// Purpose: Instruction sequencer issuing APB transfers
// Assumes: Called right after a rising edge
// Notes: Idles one cycle between transfers
`timescale 1ns/1ps
module sequencer_model (
	input wire clk_i,
	input wire pready_i,
	output logic psel_o,
	output logic penable_o,
	output logic pwrite_o,
	output logic [11:0] paddr_o,
	output logic [31:0] pwdata_o
);
	initial begin
		psel_o = 0;
		penable_o = 0;
		pwrite_o = 0;
		paddr_o = 0;
		pwdata_o = 0;
	end
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel_o <= 1;
		pwrite_o <= w;
		paddr_o <= a;
		pwdata_o <= d;
		@(posedge clk_i);
		penable_o <= 1;
		@(posedge clk_i);
		while (pready_i !== 1'b1) @(posedge clk_i);
		psel_o <= 0;
		penable_o <= 0;
		paddr_o <= ~a;
		pwdata_o <= ~d;
		@(posedge clk_i);
	endtask
endmodule

// ---- verif/word_shift_rotate_unit_bench.sv ----
// Purpose: Self-checking bench of the shift unit
// Assumes: Default depth and area split
// Notes: Read results queued, compared by a watcher
`timescale 1ns/1ps
`include "word_shift_rotate_unit_regs.vh"
module word_shift_rotate_unit_bench;
	logic clk_i = 0;
	logic rst_n_i = 0;
	logic psel, pen, pwr, rdy, err, irq;
	logic [11:0] addr;
	logic [31:0] wd, rdat;
	logic [32:0] exp_q[$];
	int bad_count = 0;
	int n_compared = 0;
	logic [127:0] pat = 128'h5678_4567_0000_3456_2345_0000_0000_1234;
	logic [15:0] v, r;
	logic [2:0] op;
	logic cy, c, z;
	always #2.5 clk_i = ~clk_i;
	word_shift_rotate_unit u_word_shift_rotate_unit (.clk_i(clk_i),
		.rst_n_i(rst_n_i), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
		.paddr_i(addr), .pwdata_i(wd), .pready_o(rdy), .prdata_o(rdat),
		.pslverr_o(err), .irq_o(irq));
	sequencer_model u_sequencer_model (.clk_i(clk_i), .pready_i(rdy),
		.psel_o(psel), .penable_o(pen), .pwrite_o(pwr), .paddr_o(addr),
		.pwdata_o(wd));
	////////////////////////////////////////////////////////////////
	task check(input logic [32:0] seen, input logic [32:0] want);
		n_compared++;
		if (seen !== want) begin
			bad_count++;
			$display("[FAIL] %0t got %h want %h", $time, seen, want);
		end
	endtask
	task wr(input logic [11:0] a, input logic [15:0] d);
		u_sequencer_model.xfer(1'b1, a, {16'h0000, d});
	endtask
	task rd(input logic [11:0] a, input logic [32:0] e);
		exp_q.push_back(e);
		u_sequencer_model.xfer(1'b0, a, 32'h0000_0000);
	endtask
	task swap(input logic [15:0] ct, lo, hi, cmd, input logic [127:0] e,
		input logic f);
		for (int i = 0; i < 8; i++) wr(12'(`MEM_BASE + 4 * i), pat[16*i+:16]);
		wr(`CTRL_OFS, ct);
		wr(`LOWER_OFS, lo);
		wr(`UPPER_OFS, hi);
		wr(`CMD_OFS, cmd);
		for (int i = 0; i < 8; i++) rd(12'(`MEM_BASE + 4 * i), e[16*i+:16]);
		rd(`FLAGS_OFS, {f, 2'b00});
	endtask
	task finish_test;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge clk_i)
		if (psel && pen && rdy === 1'b1 && !pwr)
			check({err, rdat}, exp_q.pop_front());
	initial begin
		#100000;
		bad_count++;
		finish_test;
	end
	////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h6c61f221));
		repeat (16) @(posedge clk_i);
		rst_n_i <= 1;
		@(posedge clk_i);
		swap(16'h4000 | 16'($urandom) & 16'h1FFF, 0, 7, 16'h0008,
			128'h5678_4567_3456_0000_2345_0000_1234_0000, 0);
		swap(16'h6000, 0, 7, 16'h0008,
			128'h5678_0000_4567_3456_0000_2345_0000_1234, 0);
		swap(16'h2000, 0, 7, 16'h0008, pat, 0);
		swap(16'h4000, 0, 7, 16'h0000, pat, 0);
		swap(16'hC000, 2, 5, 16'h0008,
			128'h5678_4567_0000_0000_0000_0000_0000_1234, 0);
		swap(16'h4000, 5, 2, 16'h0008, pat, 1);
		swap(16'h4000, 6, 9, 16'h0008, pat, 1);
		swap(16'h4000, 16'h000A, 7, 16'h0018, pat, 1);
		$display("zero-swap tests done");
		rd(`IRQ_STAT_OFS, 33'h3);
		wr(`IRQ_EN_OFS, 16'h0002);
		check(irq, 1);
		wr(`IRQ_CLR_OFS, 16'h0002);
		check(irq, 0);
		wr(`IRQ_EN_OFS, 16'h0001);
		check(irq, 1);
		wr(`IRQ_CLR_OFS, 16'h0003);
		check(irq, 0);
		rd(12'h024, {1'b1, 32'h0000_0000});
		$display("interrupt tests done");
		z = 0;
		for (int i = 0; i < 10; i++) begin
			v = (i == 0) ? 16'h8000 : 16'($urandom);
			cy = 1'($urandom);
			op = 3'(1 + i % 4);
			wr(`OPND_OFS, 16'h0000);
			wr(`MEM_BASE, v);
			wr(`CMD_OFS, cy ? 16'h000D : 16'h000E);
			wr(`CMD_OFS, {12'h000, i != 9, op});
			case (op)
				`OP_ASL: {c, r} = {v, 1'b0};
				`OP_ASR: {r, c} = {1'b0, v};
				`OP_ROL: {c, r} = {v, cy};
				default: {r, c} = {cy, v};
			endcase
			if (i == 9) {r, c} = {v, cy};
			else z = (r == 0);
			rd(`MEM_BASE, r);
			rd(`FLAGS_OFS, {z, c});
		end
		wr(`OPND_OFS, 16'h0016);
		wr(`CMD_OFS, 16'h0019);
		rd(`FLAGS_OFS, {1'b1, z, c});
		rd(`MEM_BASE, r);
		wr(12'(`MEM_BASE + 48), 16'h0001);
		wr(`OPND_OFS, 16'h0012);
		wr(`CMD_OFS, 16'h001A);
		rd(12'(`MEM_BASE + 48), 33'h0);
		rd(`FLAGS_OFS, 33'h3);
		$display("shift and rotate tests done");
		finish_test;
	end
endmodule
